// ### common/mrw_pkg.sv
// Package: offsets, reset values and widths of the module register window
package mrw_pkg;
  localparam int unsigned WIN_BYTES = 256;
  localparam logic [7:0] OFS_A_IN      = 8'h00;
  localparam logic [7:0] OFS_B_IN      = 8'h01;
  localparam logic [7:0] OFS_A_MODE    = 8'h02;
  localparam logic [7:0] OFS_B_MODE    = 8'h03;
  localparam logic [7:0] OFS_A_OUT     = 8'h04;
  localparam logic [7:0] OFS_B_OUT     = 8'h05;
  localparam logic [7:0] OFS_A_DIR     = 8'h06;
  localparam logic [7:0] OFS_B_DIR     = 8'h07;
  localparam logic [7:0] OFS_A_DRV     = 8'h08;
  localparam logic [7:0] OFS_B_DRV     = 8'h09;
  localparam logic [7:0] OFS_A_ICELL   = 8'h0A;
  localparam logic [7:0] OFS_B_ICELL   = 8'h0B;
  localparam logic [7:0] OFS_A_OESTAT  = 8'h0C;
  localparam logic [7:0] OFS_B_OESTAT  = 8'h0D;
  localparam logic [7:0] OFS_C_IN      = 8'h10;
  localparam logic [7:0] OFS_D_IN      = 8'h11;
  localparam logic [7:0] OFS_C_OUT     = 8'h12;
  localparam logic [7:0] OFS_D_OUT     = 8'h13;
  localparam logic [7:0] OFS_C_DIR     = 8'h14;
  localparam logic [7:0] OFS_D_DIR     = 8'h15;
  localparam logic [7:0] OFS_C_DRV     = 8'h16;
  localparam logic [7:0] OFS_D_DRV     = 8'h17;
  localparam logic [7:0] OFS_C_ICELL   = 8'h18;
  localparam logic [7:0] OFS_C_OESTAT  = 8'h1A;
  localparam logic [7:0] OFS_D_OESTAT  = 8'h1B;
  localparam logic [7:0] OFS_CELLS_AB  = 8'h20;
  localparam logic [7:0] OFS_CELLS_BC  = 8'h21;
  localparam logic [7:0] OFS_BLOCK_AB  = 8'h22;
  localparam logic [7:0] OFS_BLOCK_BC  = 8'h23;
  localparam logic [7:0] OFS_PWR0      = 8'hB0;
  localparam logic [7:0] OFS_PWR2      = 8'hB4;
  localparam logic [7:0] OFS_MAIN_LOCK = 8'hC0;
  localparam logic [7:0] OFS_BOOT_LOCK = 8'hC2;
  localparam logic [7:0] OFS_PAGE      = 8'hE0;
  localparam logic [7:0] OFS_MAPPING   = 8'hE2;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  // Programming path codes
  localparam logic [1:0] PATH_NONE     = 2'h0;
  localparam logic [1:0] PATH_CPU      = 2'h1;
  localparam logic [1:0] PATH_JTAG     = 2'h2;
  localparam logic [1:0] PATH_EXTPROG  = 2'h3;
  // Target block codes
  localparam logic [1:0] TGT_MAIN      = 2'h0;
  localparam logic [1:0] TGT_BOOT      = 2'h1;
  localparam logic [1:0] TGT_LOGIC     = 2'h2;
  localparam logic [1:0] TGT_CONFIG    = 2'h3;
endpackage : mrw_pkg

// ### hdl/mrw_register_window.sv
// Module: byte-wide register window of the memory-and-logic module
// Functional notes
// - Offsets decode from relocatable 256-byte window base.
// - Pin input registers return pin levels two clocks late.
// - Ports A, B mode registers select address output.
// - Output value registers drive processor-output pins.
// - Direction registers set each pin in or out unless its A, B mode bit forces out.
// - Drive type selects open-drain or fast slew.
// - Enable-state registers read live driver enables.
// - Logic cell reads outputs; writes load flip-flops.
// - Block bits protect matching cell flip-flops from processor writes.
// - Main flash lock register is read-only.
// - Boot lock register reports security, sector locks.
// - Mapping register places areas in program/data.
// - Processor programming may alter only flash memories.
// - JTAG programs whole module without processor.
// - Page register extends address space 256-fold.
`timescale 1ns/1ps
module mrw_register_window
  import mrw_pkg::*;
#(
  parameter int unsigned ADDR_W = 16
)(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [ADDR_W-1:0] window_base,
  input  wire logic              register_window_select,
  input  wire logic              bus_rd,
  input  wire logic              bus_wr,
  input  wire logic [7:0]        bus_wdata,
  output logic      [7:0]        bus_rdata,
  input  wire logic [7:0]        port_a_pin,
  input  wire logic [7:0]        port_b_pin,
  input  wire logic [7:0]        port_c_pin,
  input  wire logic [7:0]        port_d_pin,
  output logic      [7:0]        port_a_out,
  output logic      [7:0]        port_b_out,
  output logic      [7:0]        port_c_out,
  output logic      [7:0]        port_d_out,
  output logic      [7:0]        port_a_oe_n,
  output logic      [7:0]        port_b_oe_n,
  output logic      [7:0]        port_c_oe_n,
  output logic      [7:0]        port_d_oe_n,
  input  wire logic [7:0]        port_a_addr_out,
  input  wire logic [7:0]        port_b_addr_out,
  output logic      [7:0]        port_a_drive_type,
  output logic      [7:0]        port_b_drive_type,
  output logic      [7:0]        port_c_drive_type,
  output logic      [7:0]        port_d_drive_type,
  input  wire logic [7:0]        port_a_input_cells,
  input  wire logic [7:0]        port_b_input_cells,
  input  wire logic [7:0]        port_c_input_cells,
  input  wire logic [7:0]        general_logic_array_ab_next,
  input  wire logic [7:0]        general_logic_array_bc_next,
  input  wire logic              general_logic_array_step,
  output logic      [7:0]        logic_cells_ab,
  output logic      [7:0]        logic_cells_bc,
  input  wire logic [7:0]        main_sector_lock,
  input  wire logic [7:0]        boot_lock_security,
  output logic      [7:0]        power_control_0,
  output logic      [7:0]        power_control_2,
  output logic      [7:0]        address_page,
  output logic      [7:0]        memory_space_mapping,
  input  wire logic [1:0]        prog_path,
  input  wire logic [1:0]        prog_target,
  input  wire logic              prog_req,
  output logic                   prog_grant,
  output logic                   prog_deny
);

  // Bus-visible registers, each a single byte wide, then the one-bit grant_r and deny_r flags
  logic [7:0] a_mode_r;
  logic [7:0] b_mode_r;
  logic [7:0] a_out_r;
  logic [7:0] b_out_r;
  logic [7:0] c_out_r;
  logic [7:0] d_out_r;
  logic [7:0] a_dir_r;
  logic [7:0] b_dir_r;
  logic [7:0] c_dir_r;
  logic [7:0] d_dir_r;
  logic [7:0] a_drv_r;
  logic [7:0] b_drv_r;
  logic [7:0] c_drv_r;
  logic [7:0] d_drv_r;
  logic [7:0] cells_ab_r;
  logic [7:0] cells_bc_r;
  logic [7:0] block_ab_r;
  logic [7:0] block_bc_r;
  logic [7:0] pwr0_r;
  logic [7:0] pwr2_r;
  logic [7:0] page_r;
  logic [7:0] map_r;
  logic [7:0] rdata_r;
  logic       grant_r;
  logic       deny_r;

  // Pin levels arrive from outside the bus clock domain; a read sees them
  // two clocks late, the price of keeping metastability off the read mux
  logic [7:0] a_pin_s1;
  logic [7:0] a_pin_s2;
  logic [7:0] b_pin_s1;
  logic [7:0] b_pin_s2;
  logic [7:0] c_pin_s1;
  logic [7:0] c_pin_s2;
  logic [7:0] d_pin_s1;
  logic [7:0] d_pin_s2;

  logic [ADDR_W-1:0] rel_addr;
  logic              in_window;
  logic [7:0]        ofs;
  logic              wr_hit;
  logic              rd_hit;
  logic              ab_load;
  logic              bc_load;
  logic [7:0]        a_oe;
  logic [7:0]        b_oe;
  logic [7:0]        c_oe;
  logic [7:0]        d_oe;
  logic [7:0]        a_val;
  logic [7:0]        b_val;
  logic [7:0]        rd_nxt;

  // Write merge: bits set in the block mask keep their old value
  function automatic logic [7:0] masked_load(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic [7:0] blk);
    masked_load = (old_v & blk) | (new_v & ~blk);
  endfunction : masked_load

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      a_pin_s1 <= RST_BYTE;
      a_pin_s2 <= RST_BYTE;
      b_pin_s1 <= RST_BYTE;
      b_pin_s2 <= RST_BYTE;
      c_pin_s1 <= RST_BYTE;
      c_pin_s2 <= RST_BYTE;
      d_pin_s1 <= RST_BYTE;
      d_pin_s2 <= RST_BYTE;
    end
    else
    begin
      a_pin_s1 <= port_a_pin;
      a_pin_s2 <= a_pin_s1;
      b_pin_s1 <= port_b_pin;
      b_pin_s2 <= b_pin_s1;
      c_pin_s1 <= port_c_pin;
      c_pin_s2 <= c_pin_s1;
      d_pin_s1 <= port_d_pin;
      d_pin_s2 <= d_pin_s1;
    end
  end

  // Offset relative to the user-placed base; the window spans 256 bytes
  assign rel_addr  = bus_addr - window_base;
  assign in_window = register_window_select
                     && (rel_addr < ADDR_W'(WIN_BYTES));
  assign ofs       = rel_addr[7:0];
  assign wr_hit    = in_window && bus_wr;
  assign rd_hit    = in_window && bus_rd;
  // Macrocell loads; the mask only guards against these processor writes
  assign ab_load   = wr_hit && (ofs == OFS_CELLS_AB);
  assign bc_load   = wr_hit && (ofs == OFS_CELLS_BC);

  // Direction bit 1 drives the pin; enables are low while driving
  assign a_oe = a_dir_r | a_mode_r;
  assign b_oe = b_dir_r | b_mode_r;
  assign c_oe = c_dir_r;
  assign d_oe = d_dir_r;
  // Mode bit 1 hands the pin to the latched address
  assign a_val = (a_mode_r & port_a_addr_out) | (~a_mode_r & a_out_r);
  assign b_val = (b_mode_r & port_b_addr_out) | (~b_mode_r & b_out_r);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      a_mode_r <= RST_BYTE;
      b_mode_r <= RST_BYTE;
      a_out_r  <= RST_BYTE;
      b_out_r  <= RST_BYTE;
      c_out_r  <= RST_BYTE;
      d_out_r  <= RST_BYTE;
      a_dir_r  <= RST_BYTE;
      b_dir_r  <= RST_BYTE;
      c_dir_r  <= RST_BYTE;
      d_dir_r  <= RST_BYTE;
      a_drv_r  <= RST_BYTE;
      b_drv_r  <= RST_BYTE;
      c_drv_r  <= RST_BYTE;
      d_drv_r  <= RST_BYTE;
    end
    else if (wr_hit)
    begin
      if (ofs == OFS_A_MODE)      a_mode_r <= bus_wdata;
      else if (ofs == OFS_B_MODE) b_mode_r <= bus_wdata;
      else if (ofs == OFS_A_OUT)  a_out_r  <= bus_wdata;
      else if (ofs == OFS_B_OUT)  b_out_r  <= bus_wdata;
      else if (ofs == OFS_C_OUT)  c_out_r  <= bus_wdata;
      else if (ofs == OFS_D_OUT)  d_out_r  <= bus_wdata;
      else if (ofs == OFS_A_DIR)  a_dir_r  <= bus_wdata;
      else if (ofs == OFS_B_DIR)  b_dir_r  <= bus_wdata;
      else if (ofs == OFS_C_DIR)  c_dir_r  <= bus_wdata;
      else if (ofs == OFS_D_DIR)  d_dir_r  <= bus_wdata;
      else if (ofs == OFS_A_DRV)  a_drv_r  <= bus_wdata;
      else if (ofs == OFS_B_DRV)  b_drv_r  <= bus_wdata;
      else if (ofs == OFS_C_DRV)  c_drv_r  <= bus_wdata;
      else if (ofs == OFS_D_DRV)  d_drv_r  <= bus_wdata;
    end
  end

  // Macrocells: a processor load wins over the array step in the same cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cells_ab_r <= RST_BYTE;
      cells_bc_r <= RST_BYTE;
    end
    else
    begin
      if (ab_load)
        cells_ab_r <= masked_load(cells_ab_r, bus_wdata, block_ab_r);
      else if (general_logic_array_step)
        cells_ab_r <= general_logic_array_ab_next;
      if (bc_load)
        cells_bc_r <= masked_load(cells_bc_r, bus_wdata, block_bc_r);
      else if (general_logic_array_step)
        cells_bc_r <= general_logic_array_bc_next;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      block_ab_r <= RST_BYTE;
      block_bc_r <= RST_BYTE;
      pwr0_r     <= RST_BYTE;
      pwr2_r     <= RST_BYTE;
      page_r     <= RST_BYTE;
      map_r      <= RST_BYTE;
    end
    else if (wr_hit)
    begin
      // Lock offsets and unassigned offsets fall through: writes are dropped
      if (ofs == OFS_BLOCK_AB)      block_ab_r <= bus_wdata;
      else if (ofs == OFS_BLOCK_BC) block_bc_r <= bus_wdata;
      else if (ofs == OFS_PWR0)     pwr0_r     <= bus_wdata;
      else if (ofs == OFS_PWR2)     pwr2_r     <= bus_wdata;
      else if (ofs == OFS_PAGE)     page_r     <= bus_wdata;
      else if (ofs == OFS_MAPPING)  map_r      <= bus_wdata;
    end
  end

  // Read mux: each register byte-wide, zero elsewhere in the window
  always_comb
  begin
    rd_nxt = RST_BYTE;
    if (ofs == OFS_A_IN)           rd_nxt = a_pin_s2;
    else if (ofs == OFS_B_IN)      rd_nxt = b_pin_s2;
    else if (ofs == OFS_C_IN)      rd_nxt = c_pin_s2;
    else if (ofs == OFS_D_IN)      rd_nxt = d_pin_s2;
    else if (ofs == OFS_A_MODE)    rd_nxt = a_mode_r;
    else if (ofs == OFS_B_MODE)    rd_nxt = b_mode_r;
    else if (ofs == OFS_A_OUT)     rd_nxt = a_out_r;
    else if (ofs == OFS_B_OUT)     rd_nxt = b_out_r;
    else if (ofs == OFS_C_OUT)     rd_nxt = c_out_r;
    else if (ofs == OFS_D_OUT)     rd_nxt = d_out_r;
    else if (ofs == OFS_A_DIR)     rd_nxt = a_dir_r;
    else if (ofs == OFS_B_DIR)     rd_nxt = b_dir_r;
    else if (ofs == OFS_C_DIR)     rd_nxt = c_dir_r;
    else if (ofs == OFS_D_DIR)     rd_nxt = d_dir_r;
    else if (ofs == OFS_A_DRV)     rd_nxt = a_drv_r;
    else if (ofs == OFS_B_DRV)     rd_nxt = b_drv_r;
    else if (ofs == OFS_C_DRV)     rd_nxt = c_drv_r;
    else if (ofs == OFS_D_DRV)     rd_nxt = d_drv_r;
    else if (ofs == OFS_A_ICELL)   rd_nxt = port_a_input_cells;
    else if (ofs == OFS_B_ICELL)   rd_nxt = port_b_input_cells;
    else if (ofs == OFS_C_ICELL)   rd_nxt = port_c_input_cells;
    else if (ofs == OFS_A_OESTAT)  rd_nxt = a_oe;
    else if (ofs == OFS_B_OESTAT)  rd_nxt = b_oe;
    else if (ofs == OFS_C_OESTAT)  rd_nxt = c_oe;
    else if (ofs == OFS_D_OESTAT)  rd_nxt = d_oe;
    else if (ofs == OFS_CELLS_AB)  rd_nxt = cells_ab_r;
    else if (ofs == OFS_CELLS_BC)  rd_nxt = cells_bc_r;
    else if (ofs == OFS_BLOCK_AB)  rd_nxt = block_ab_r;
    else if (ofs == OFS_BLOCK_BC)  rd_nxt = block_bc_r;
    else if (ofs == OFS_PWR0)      rd_nxt = pwr0_r;
    else if (ofs == OFS_PWR2)      rd_nxt = pwr2_r;
    else if (ofs == OFS_MAIN_LOCK) rd_nxt = main_sector_lock;
    else if (ofs == OFS_BOOT_LOCK) rd_nxt = boot_lock_security;
    else if (ofs == OFS_PAGE)      rd_nxt = page_r;
    else if (ofs == OFS_MAPPING)   rd_nxt = map_r;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_r <= RST_BYTE;
    // Holds between reads so a slow consumer can still sample it
    else if (rd_hit)
      rdata_r <= rd_nxt;
  end

  // Programming-path gate; JTAG and the external programmer reach every
  // block with no processor involvement
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      grant_r <= 1'b0;
      deny_r  <= 1'b0;
    end
    else if (prog_req)
    begin
      if (prog_path == PATH_JTAG || prog_path == PATH_EXTPROG)
      begin
        grant_r <= 1'b1;
        deny_r  <= 1'b0;
      end
      else if (prog_path == PATH_CPU
               && (prog_target == TGT_MAIN || prog_target == TGT_BOOT))
      begin
        grant_r <= 1'b1;
        deny_r  <= 1'b0;
      end
      else
      begin
        // Processor path to the arrays or configuration, or no path named
        grant_r <= 1'b0;
        deny_r  <= 1'b1;
      end
    end
    else
    begin
      grant_r <= 1'b0;
      deny_r  <= 1'b0;
    end
  end

  // Pin-side and fabric-side copies of the register contents
  assign bus_rdata            = rdata_r;
  assign port_a_out           = a_val;
  assign port_b_out           = b_val;
  assign port_c_out           = c_out_r;
  assign port_d_out           = d_out_r;
  assign port_a_oe_n          = ~a_oe;
  assign port_b_oe_n          = ~b_oe;
  assign port_c_oe_n          = ~c_oe;
  assign port_d_oe_n          = ~d_oe;
  assign port_a_drive_type    = a_drv_r;
  assign port_b_drive_type    = b_drv_r;
  assign port_c_drive_type    = c_drv_r;
  assign port_d_drive_type    = d_drv_r;
  assign logic_cells_ab       = cells_ab_r;
  assign logic_cells_bc       = cells_bc_r;
  assign power_control_0      = pwr0_r;
  assign power_control_2      = pwr2_r;
  assign address_page         = page_r;
  assign memory_space_mapping = map_r;
  assign prog_grant           = grant_r;
  assign prog_deny            = deny_r;

endmodule : mrw_register_window

// ### test/mrw_window_props.sv
// Checker: decode, port and programming-gate relations at the window ports
`timescale 1ns/1ps
module mrw_window_props
  import mrw_pkg::*;
#(
  parameter int unsigned ADDR_W = 16
)(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [ADDR_W-1:0] window_base,
  input wire logic              register_window_select,
  input wire logic              bus_rd,
  input wire logic              bus_wr,
  input wire logic [7:0]        bus_wdata,
  input wire logic [7:0]        bus_rdata,
  input wire logic [7:0]        port_c_out,
  input wire logic [7:0]        port_c_oe_n,
  input wire logic [7:0]        main_sector_lock,
  input wire logic [7:0]        address_page,
  input wire logic [1:0]        prog_path,
  input wire logic [1:0]        prog_target,
  input wire logic              prog_req,
  input wire logic              prog_grant,
  input wire logic              prog_deny
);
  logic [ADDR_W-1:0] ofs;
  logic              hit;
  logic              cfg_tgt;
  assign ofs = bus_addr - window_base;
  // Wraps below the base give huge offsets, so one compare covers both sides
  assign hit = register_window_select && (ofs < WIN_BYTES);
  assign cfg_tgt = prog_target[1];
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  c_out_load_a: assert property (hit && bus_wr && ofs == OFS_C_OUT
    |=> port_c_out == $past(bus_wdata)) else $error("port C output not loaded");
  c_dir_enable_a: assert property (hit && bus_wr && ofs == OFS_C_DIR
    |=> port_c_oe_n == ~$past(bus_wdata)) else $error("port C enables wrong");
  page_load_a: assert property (hit && bus_wr && ofs == OFS_PAGE
    |=> address_page == $past(bus_wdata)) else $error("page register not loaded");
  unmapped_zero_a: assert property (hit && bus_rd && ofs == 8'hFF
    |=> bus_rdata == 8'h00) else $error("unassigned offset read not zero");
  main_lock_a: assert property (hit && bus_rd && ofs == OFS_MAIN_LOCK
    |=> bus_rdata == $past(main_sector_lock)) else $error("main lock read wrong");
  rdata_hold_a: assert property (!(hit && bus_rd) |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  outside_ignored_a: assert property (bus_wr && !hit |=> $stable(port_c_out))
    else $error("write outside window took effect");
  iap_limit_a: assert property (prog_req && prog_path == PATH_CPU
    |=> prog_deny == $past(cfg_tgt) && prog_grant == !$past(cfg_tgt))
    else $error("processor programming gate wrong");
  jtag_whole_a: assert property (prog_req && prog_path == PATH_JTAG
    |=> prog_grant && !prog_deny) else $error("JTAG programming refused");
endmodule : mrw_window_props

bind mrw_register_window mrw_window_props #(.ADDR_W(ADDR_W)) u_props (
  .clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .window_base(window_base),
  .register_window_select(register_window_select), .bus_rd(bus_rd), .bus_wr(bus_wr),
  .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .port_c_out(port_c_out),
  .port_c_oe_n(port_c_oe_n), .main_sector_lock(main_sector_lock),
  .address_page(address_page), .prog_path(prog_path), .prog_target(prog_target),
  .prog_req(prog_req), .prog_grant(prog_grant), .prog_deny(prog_deny));

// ### test/mrw_cpu_model.sv
// Processor bus model: one byte access per call on the internal bus
`timescale 1ns/1ps
module mrw_cpu_model (
  input  wire logic        clk,
  output logic      [15:0] bus_addr,
  output logic             register_window_select,
  output logic             bus_rd,
  output logic             bus_wr,
  output logic      [7:0]  bus_wdata,
  input  wire logic [7:0]  bus_rdata
);
  initial
  begin
    bus_addr = 16'h0000;
    register_window_select = 1'b0;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_wdata = 8'h00;
  end
  // Released address and data lines show the inverse so stale values never look valid
  task automatic cycle(input logic [15:0] a, input logic sel, input logic rd,
                       input logic wr, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    bus_addr = a;
    register_window_select = sel;
    bus_rd = rd;
    bus_wr = wr;
    bus_wdata = d;
    @(negedge clk);
    q = bus_rdata;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    register_window_select = 1'b0;
    bus_addr = ~a;
    bus_wdata = ~d;
  endtask : cycle
endmodule : mrw_cpu_model

// ### test/testbench.sv
// Testbench: register window scenarios driven through the processor model; the programming gate is driven directly
`timescale 1ns/1ps
module testbench
  import mrw_pkg::*;
;
  logic        clk, sys_rst, sel, rd, wr, prog_req, step, grant, deny;
  logic [15:0] addr, base;
  logic [7:0]  wd, rdata, pa, pb, pc, pd, ada, adb, ica, icb, icc, mlk, blk, q;
  logic [7:0]  oa, ob, oc, od, ea, eb, ec, ed, cab, nab, dtc, pg, vmap;
  logic [1:0]  path, tgt;
  int          mismatches, num_checks;
  mrw_cpu_model u_cpu (.clk(clk), .bus_addr(addr), .register_window_select(sel),
    .bus_rd(rd), .bus_wr(wr), .bus_wdata(wd), .bus_rdata(rdata));
  mrw_register_window #(.ADDR_W(16)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .bus_addr(addr), .window_base(base), .register_window_select(sel), .bus_rd(rd),
    .bus_wr(wr), .bus_wdata(wd), .bus_rdata(rdata), .port_a_pin(pa), .port_b_pin(pb),
    .port_c_pin(pc), .port_d_pin(pd), .port_a_out(oa), .port_b_out(ob), .port_c_out(oc),
    .port_d_out(od), .port_a_oe_n(ea), .port_b_oe_n(eb), .port_c_oe_n(ec),
    .port_d_oe_n(ed), .port_a_addr_out(ada), .port_b_addr_out(adb),
    .port_a_drive_type(), .port_b_drive_type(), .port_c_drive_type(dtc),
    .port_d_drive_type(), .port_a_input_cells(ica), .port_b_input_cells(icb),
    .port_c_input_cells(icc), .general_logic_array_ab_next(nab),
    .general_logic_array_bc_next(8'h00), .general_logic_array_step(step),
    .logic_cells_ab(cab), .logic_cells_bc(), .main_sector_lock(mlk),
    .boot_lock_security(blk), .power_control_0(), .power_control_2(), .address_page(pg),
    .memory_space_mapping(vmap), .prog_path(path), .prog_target(tgt), .prog_req(prog_req),
    .prog_grant(grant), .prog_deny(deny));
  localparam logic [7:0] RW_OFS [20] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h08, 8'h09, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h22, 8'h23, 8'hB0,
    8'hB4, 8'hE0, 8'hE2};
  always #25 clk = ~clk;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wrr(input logic [7:0] o, input logic [7:0] d);
    u_cpu.cycle(base + {8'h00, o}, 1'b1, 1'b0, 1'b1, d, q);
  endtask : wrr
  task automatic rdr(input logic [7:0] o, output logic [7:0] v);
    u_cpu.cycle(base + {8'h00, o}, 1'b1, 1'b1, 1'b0, 8'h00, v);
  endtask : rdr
  task automatic t_reset;
    logic [7:0] v;
    foreach (RW_OFS[i])
    begin
      rdr(RW_OFS[i], v);
      chk("reset value", 8'h00, v);
    end
    chk("enables after reset", 8'hFF, ea & eb & ec & ed);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_rw;
    logic [7:0] v;
    foreach (RW_OFS[i])
      wrr(RW_OFS[i], RW_OFS[i] ^ 8'hA5);
    foreach (RW_OFS[i])
    begin
      rdr(RW_OFS[i], v);
      chk("read back", RW_OFS[i] ^ 8'hA5, v);
    end
    chk("port C drive type", 8'hB3, dtc);
    chk("page output", 8'h45, pg);
    chk("mapping output", 8'h47, vmap);
    $display("t_rw done");
  endtask : t_rw
  task automatic t_readonly;
    logic [7:0] v;
    wrr(OFS_MAIN_LOCK, 8'h00);
    wrr(OFS_BOOT_LOCK, 8'h00);
    wrr(OFS_A_IN, 8'h00);
    wrr(8'hFF, 8'h77);
    rdr(OFS_A_IN, v);
    chk("port A pins", 8'h3C, v);
    rdr(OFS_D_IN, v);
    chk("port D pins", 8'h96, v);
    rdr(OFS_C_ICELL, v);
    chk("port C input cells", 8'h5A, v);
    rdr(OFS_MAIN_LOCK, v);
    chk("main lock", 8'h0F, v);
    rdr(OFS_BOOT_LOCK, v);
    chk("boot lock", 8'h83, v);
    rdr(8'hFF, v);
    chk("unassigned", 8'h00, v);
    $display("t_readonly done");
  endtask : t_readonly
  task automatic t_ports;
    logic [7:0] v;
    wrr(OFS_A_MODE, 8'hF0);
    wrr(OFS_A_DIR, 8'h0F);
    wrr(OFS_A_OUT, 8'h55);
    wrr(OFS_C_DIR, 8'h0F);
    wrr(OFS_C_OUT, 8'hAA);
    wrr(OFS_D_DIR, 8'h00);
    chk("port A out", 8'h35, oa);
    chk("port A enables", 8'h00, ea);
    chk("port C enables", 8'hF0, ec);
    chk("port C out", 8'hAA, oc);
    chk("port D enables", 8'hFF, ed);
    rdr(OFS_C_OESTAT, v);
    chk("port C enable state", 8'h0F, v);
    rdr(OFS_A_OESTAT, v);
    chk("port A enable state", 8'hFF, v);
    $display("t_ports done");
  endtask : t_ports
  task automatic t_mask;
    logic [7:0] v;
    wrr(OFS_BLOCK_AB, 8'h00);
    wrr(OFS_CELLS_AB, 8'hA5);
    wrr(OFS_BLOCK_AB, 8'hF0);
    wrr(OFS_CELLS_AB, 8'h0F);
    chk("cells AB", 8'hAF, cab);
    rdr(OFS_CELLS_AB, v);
    chk("cells AB read", 8'hAF, v);
    // Array step loads 3C in the idle cycle, then the masked write wins
    step = 1'b1;
    nab = 8'h3C;
    wrr(OFS_CELLS_AB, 8'h01);
    step = 1'b0;
    chk("cells AB step then write", 8'h31, cab);
    $display("t_mask done");
  endtask : t_mask
  task automatic t_window;
    @(negedge clk);
    base = 16'h8000;
    wrr(OFS_C_OUT, 8'h5A);
    u_cpu.cycle(16'h0012, 1'b1, 1'b0, 1'b1, 8'h3C, q);
    u_cpu.cycle(16'h8112, 1'b1, 1'b0, 1'b1, 8'h3C, q);
    u_cpu.cycle(16'h8012, 1'b0, 1'b0, 1'b1, 8'h3C, q);
    chk("port C out kept", 8'h5A, oc);
    $display("t_window done");
  endtask : t_window
  task automatic t_prog;
    for (int p = 1; p < 4; p++)
      for (int t = 0; t < 4; t++)
      begin
        @(negedge clk);
        prog_req = 1'b1;
        path = 2'(p);
        tgt = 2'(t);
        @(negedge clk);
        prog_req = 1'b0;
        chk("grant,deny", (p == 1 && t > 1) ? 8'h01 : 8'h02, {6'h00, grant, deny});
      end
    $display("t_prog done");
  endtask : t_prog
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {prog_req, step, path, tgt, base, nab} = '0;
    {pa, pb, pc, pd, ada, adb} = {8'h3C, 8'h11, 8'h22, 8'h96, 8'h3C, 8'h00};
    {ica, icb, icc, mlk, blk} = {8'h01, 8'h02, 8'h5A, 8'h0F, 8'h83};
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_rw();
    t_readonly();
    t_ports();
    t_mask();
    t_window();
    t_prog();
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule : testbench
